// [core/bfs_supervisor.sv]
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module bfs_supervisor #(
   parameter int BOOT_PERIOD_CYC = bfs_pkg::BOOT_PERIOD_CYC,
   parameter int BOOT_PULSE_CYC = bfs_pkg::BOOT_PULSE_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [bfs_pkg::AW-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [bfs_pkg::DW-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [bfs_pkg::DW-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_pair_one_hold_n,
   input wire logic i_pair_two_hold_n,
   input wire logic i_gate_drive_supply_ok,
   input wire logic i_common_supply_ok,
   input wire logic [bfs_pkg::NHB-1:0] i_overcurrent,
   input wire logic i_overtemp_warn,
   input wire logic i_thermal_shutdown,
   input wire logic [bfs_pkg::NHB-1:0] i_boot_cap_undervolt,
   input wire logic [bfs_pkg::NHB-1:0] i_duty_too_high,
   output logic [bfs_pkg::NHB-1:0] o_bridge_enable,
   output logic [bfs_pkg::NHB-1:0] o_weak_pulldown,
   output logic [bfs_pkg::NHB-1:0] o_high_side_off,
   output logic o_fault_n_o,
   output logic o_fault_n_oe,
   output logic o_overtemp_warn_n_o,
   output logic o_overtemp_warn_n_oe,
   output logic o_irq
);
   import bfs_pkg::*;

   localparam int NSYNC = 2 + 2 + NHB + 2 + NHB + NHB;

   if (BOOT_PULSE_CYC < 1 || BOOT_PULSE_CYC >= BOOT_PERIOD_CYC ||
       BOOT_PERIOD_CYC >= (1 << BOOT_CNT_W)) begin : g_bad_timing
      $error("bfs_supervisor: recharge timing out of range");
   end

   // ==========================================
   // input synchronisation
   logic [1:0] hold_s;
   logic gate_ok_s;
   logic common_ok_s;
   logic [NHB-1:0] oc_s;
   logic warn_s;
   logic thermal_shutdown_s;
   logic [NHB-1:0] boot_uv_s;
   logic [NHB-1:0] duty_s;

   bfs_sync_if #(.W(NSYNC)) sync_bus ();

   assign sync_bus.raw = {i_pair_two_hold_n, i_pair_one_hold_n, i_gate_drive_supply_ok,
                          i_common_supply_ok, i_overcurrent, i_overtemp_warn,
                          i_thermal_shutdown, i_boot_cap_undervolt, i_duty_too_high};
   assign {hold_s, gate_ok_s, common_ok_s, oc_s, warn_s, thermal_shutdown_s, boot_uv_s, duty_s} =
      sync_bus.clean;

   bfs_sync #(.W(NSYNC)) u_sync (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .bus(sync_bus.filt)
   );

   // ==========================================
   // fault state
   logic [1:0] hold_prev_reg;
   logic oc_latch_reg;
   logic ot_latch_reg;
   logic warn_prev_reg;
   logic uv_prev_reg;
   logic half_mode_reg;
   logic hold_rise;
   logic holds_high;
   logic uv_now;
   logic oc_any;
   logic shutdown_now;

   assign hold_rise = |(hold_s & ~hold_prev_reg);
   assign holds_high = &hold_s;
   assign uv_now = ~gate_ok_s | ~common_ok_s;
   assign oc_any = |oc_s;
   assign shutdown_now = uv_now | oc_any | thermal_shutdown_s | oc_latch_reg | ot_latch_reg;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_prev_reg <= 2'h0;
         warn_prev_reg <= 1'b0;
         // supplies read bad out of reset, so no false rise
         uv_prev_reg <= 1'b1;
      end else begin
         hold_prev_reg <= hold_s;
         warn_prev_reg <= warn_s;
         uv_prev_reg <= uv_now;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         oc_latch_reg <= 1'b0;
      end else if (oc_any) begin
         oc_latch_reg <= 1'b1;
      end else if (hold_rise) begin
         oc_latch_reg <= 1'b0;
      end
   end

   // thermal latch until both holds low
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ot_latch_reg <= 1'b0;
      end else if (thermal_shutdown_s) begin
         ot_latch_reg <= 1'b1;
      end else if (hold_s == 2'h0) begin
         ot_latch_reg <= 1'b0;
      end
   end

   // ==========================================
   // power stage and status pins
   // open-drain pins drive low only
   assign o_fault_n_o = 1'b0;
   assign o_overtemp_warn_n_o = 1'b0;

   // Hi-Z and fault pin on same edge
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_bridge_enable <= '0;
         o_fault_n_oe <= 1'b1;
      end else begin
         // each hold gates its own pair
         o_bridge_enable <= {{2{hold_s[1] & ~shutdown_now}}, {2{hold_s[0] & ~shutdown_now}}};
         o_fault_n_oe <= ~(shutdown_now & holds_high);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_overtemp_warn_n_oe <= 1'b1;
      end else begin
         o_overtemp_warn_n_oe <= ~warn_s;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_weak_pulldown <= '0;
      end else begin
         o_weak_pulldown <= {{2{~hold_s[1] & ~half_mode_reg}}, {2{~hold_s[0] & ~half_mode_reg}}};
      end
   end

   // ==========================================
   // bootstrap recharge pulses
   logic [BOOT_CNT_W-1:0] boot_cnt_reg;
   logic [NHB-1:0] boot_req;
   logic boot_window;
   logic boot_start;

   assign boot_req = boot_uv_s | duty_s;
   assign boot_window = boot_cnt_reg < BOOT_PULSE_CYC[BOOT_CNT_W-1:0];
   assign boot_start = |(boot_req & ~o_high_side_off) & boot_window;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         boot_cnt_reg <= '0;
      end else if (boot_cnt_reg == BOOT_CNT_W'(BOOT_PERIOD_CYC - 1)) begin
         boot_cnt_reg <= '0;
      end else begin
         boot_cnt_reg <= boot_cnt_reg + 1'b1;
      end
   end

   for (genvar h = 0; h < NHB; h++) begin : g_boot
      always_ff @(posedge i_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            o_high_side_off[h] <= 1'b0;
         end else begin
            o_high_side_off[h] <= boot_req[h] & boot_window;
         end
      end
   end

   // ==========================================
   // register bus slave
   logic ack_reg;
   logic wr_en;
   logic [EVW-1:0] status_reg;
   logic [EVW-1:0] mask_reg;
   logic [EVW-1:0] events;
   logic [EVW-1:0] clr;
   logic [STW-1:0] live;
   logic [DW-1:0] rd_mux;

   assign o_avs_waitrequest = ~ack_reg;
   assign wr_en = ack_reg & i_avs_write & i_avs_byteenable[0];

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
      end
   end

   always_comb begin
      live = '0;
      live[ST_UNDERVOLT] = uv_now;
      live[ST_OC_LATCH] = oc_latch_reg;
      live[ST_OT_LATCH] = ot_latch_reg;
      live[ST_WARN] = warn_s;
      live[ST_HOLD_ONE] = hold_s[0];
      live[ST_HOLD_TWO] = hold_s[1];
      live[ST_SHUTDOWN] = shutdown_now;
   end

   always_comb begin
      rd_mux = '0;
      if (i_avs_address == ADDR_STATUS) begin
         rd_mux[EVW-1:0] = status_reg;
      end else if (i_avs_address == ADDR_MASK) begin
         rd_mux[EVW-1:0] = mask_reg;
      end else if (i_avs_address == ADDR_CONTROL) begin
         rd_mux[CTL_HALF_BRIDGE] = half_mode_reg;
      end else if (i_avs_address == ADDR_STATE) begin
         rd_mux[STW-1:0] = live;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_avs_readdata <= '0;
      end else if (i_avs_read & ~ack_reg) begin
         o_avs_readdata <= rd_mux;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mask_reg <= MASK_RST;
      end else if (wr_en && i_avs_address == ADDR_MASK) begin
         mask_reg <= i_avs_writedata[EVW-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         half_mode_reg <= CONTROL_RST;
      end else if (wr_en && i_avs_address == ADDR_CONTROL) begin
         half_mode_reg <= i_avs_writedata[CTL_HALF_BRIDGE];
      end
   end

   // ==========================================
   // interrupt status, write one to clear, set wins
   always_comb begin
      events = '0;
      events[EV_UNDERVOLT] = uv_now & ~uv_prev_reg;
      events[EV_OVERCURRENT] = oc_any & ~oc_latch_reg;
      events[EV_THERMAL] = thermal_shutdown_s & ~ot_latch_reg;
      events[EV_WARN] = warn_s & ~warn_prev_reg;
      events[EV_RECHARGE] = boot_start;
   end

   assign clr = (wr_en && i_avs_address == ADDR_STATUS) ? i_avs_writedata[EVW-1:0] : '0;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         status_reg <= STATUS_RST;
      end else begin
         status_reg <= (status_reg & ~clr) | events;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(((status_reg & ~clr) | events) & mask_reg);
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   a_fault_on_shutdown: assert property (
      (shutdown_now && holds_high) |=> !o_fault_n_oe)
      else $error("fault pin not pulled low on shutdown");

   a_warn_no_stop: assert property (
      (warn_s && !shutdown_now && holds_high) |=> (!o_overtemp_warn_n_oe && &o_bridge_enable))
      else $error("warning alone changed bridges or pin");

   a_pin_pair_code: assert property (
      (warn_s && shutdown_now && holds_high) |=> ({o_fault_n_oe, o_overtemp_warn_n_oe} == 2'b00))
      else $error("status pair code wrong");

   a_hold_releases_fault: assert property (
      (!hold_s[0] || !hold_s[1]) |=> o_fault_n_oe)
      else $error("fault pin driven while hold low");

   a_hiz_with_fault: assert property (
      !o_fault_n_oe |-> (o_bridge_enable == '0))
      else $error("bridges enabled while fault reported");

   a_uv_auto_resume: assert property (
      ($fell(uv_now) && !oc_any && !thermal_shutdown_s && !oc_latch_reg && !ot_latch_reg && holds_high)
      |=> &o_bridge_enable)
      else $error("no resume after undervoltage cleared");

   a_supply_hiz: assert property (
      uv_now |=> (o_bridge_enable == '0))
      else $error("bridges on with low supply");

   a_hold_pulldown: assert property (
      (!hold_s[0] && !half_mode_reg) |=> (o_weak_pulldown[1:0] == 2'b11))
      else $error("no weak pulldown while held");

   a_pulse_cause: assert property (
      o_high_side_off[0] |-> $past(boot_req[0]))
      else $error("recharge pulse without cause");

   a_pair_isolation: assert property (
      !hold_s[1] |=> (o_bridge_enable[3:2] == 2'b00))
      else $error("pair two enabled while held");

   a_oc_clear_rise: assert property (
      (oc_latch_reg && hold_rise && !oc_any) |=> !oc_latch_reg)
      else $error("overcurrent latch not cleared by hold rise");

   a_ot_latched: assert property (
      (ot_latch_reg && hold_s != 2'h0) |=> ot_latch_reg ##0 !o_bridge_enable[0])
      else $error("thermal latch dropped early");

   c_oc_recover: cover property (oc_latch_reg ##1 !oc_latch_reg);
   c_ot_latch: cover property ($rose(ot_latch_reg));
   c_recharge: cover property ($rose(o_high_side_off[0]));
   c_irq: cover property ($rose(o_irq));
endmodule
`default_nettype wire

// [core/bfs_pkg.sv]
package bfs_pkg;
   // ==========================================
   // register bus
   localparam int AW = 4;
   localparam int DW = 32;
   localparam logic [AW-1:0] ADDR_STATUS = 4'h0;
   localparam logic [AW-1:0] ADDR_MASK = 4'h4;
   localparam logic [AW-1:0] ADDR_CONTROL = 4'h8;
   localparam logic [AW-1:0] ADDR_STATE = 4'hc;

   // ==========================================
   // status and mask layout
   localparam int EVW = 5;
   localparam int EV_UNDERVOLT = 0;
   localparam int EV_OVERCURRENT = 1;
   localparam int EV_THERMAL = 2;
   localparam int EV_WARN = 3;
   localparam int EV_RECHARGE = 4;
   localparam logic [EVW-1:0] STATUS_RST = 5'h00;
   localparam logic [EVW-1:0] MASK_RST = 5'h00;

   // ==========================================
   // control layout
   localparam int CTL_HALF_BRIDGE = 0;
   localparam logic CONTROL_RST = 1'b0;

   // ==========================================
   // live state layout
   localparam int STW = 7;
   localparam int ST_UNDERVOLT = 0;
   localparam int ST_OC_LATCH = 1;
   localparam int ST_OT_LATCH = 2;
   localparam int ST_WARN = 3;
   localparam int ST_HOLD_ONE = 4;
   localparam int ST_HOLD_TWO = 5;
   localparam int ST_SHUTDOWN = 6;

   // ==========================================
   // bridge layout
   localparam int NHB = 4;
   localparam int NPAIR = 2;

   // ==========================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BOOT_PULSE_NS = 60;
   localparam int BOOT_PERIOD_NS = 2000;
   localparam int BOOT_PULSE_CYC = (BOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BOOT_PERIOD_CYC = BOOT_PERIOD_NS / CLK_PERIOD_NS;
   localparam int BOOT_CNT_W = 16;
endpackage

// [core/bfs_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface bfs_sync_if #(
   parameter int W = 1
) ();
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface
`default_nettype wire

// [core/bfs_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module bfs_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   bfs_sync_if.filt bus
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] clean_reg;

   // ==========================================
   // three-flop chain, accept once stages two and three agree
   // synchronise all inputs
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= bus.raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // per bit, so one settling bit never blocks another
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            clean_reg[b] <= 1'b0;
         end else if (s2_reg[b] == s3_reg[b]) begin
            clean_reg[b] <= s3_reg[b];
         end
      end
   end

   assign bus.clean = clean_reg;
endmodule
`default_nettype wire

// [test/bfs_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bfs_ctrl_model (
   input wire logic i_clk,
   input wire logic i_run_one,
   input wire logic i_run_two,
   input wire logic i_fault_n_o,
   input wire logic i_fault_n_oe,
   input wire logic i_warn_n_o,
   input wire logic i_warn_n_oe,
   output logic o_pair_one_hold_n,
   output logic o_pair_two_hold_n,
   output logic o_fault_level,
   output logic o_warn_level
);
   // ==========================================
   // hold pins
   // low at power-up, high in run
   initial begin
      o_pair_one_hold_n = 1'b0;
      o_pair_two_hold_n = 1'b0;
   end
   always @(posedge i_clk) begin
      o_pair_one_hold_n <= i_run_one;
      o_pair_two_hold_n <= i_run_two;
   end

   // ==========================================
   // status pins
   // pull-up when released
   assign o_fault_level = i_fault_n_oe ? 1'b1 : i_fault_n_o;
   assign o_warn_level = i_warn_n_oe ? 1'b1 : i_warn_n_o;
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
   import bfs_pkg::*;
   localparam int PER = 20;
   localparam int PUL = 3;
   logic i_clk, i_arst_n, rd_en, wr_en, run_one, run_two, gd_ok, cm_ok, warn, therm;
   logic [3:0] addr, be, oc, buv, duty, en, pd, hso;
   logic [31:0] wdata, rdata, q;
   logic wreq, f_o, f_oe, w_o, w_oe, irq, hold1, hold2, f_lvl, w_lvl;
   int mismatches = 0;
   int cmp_count = 0;
   int c0, c2, cx;

   bfs_supervisor #(.BOOT_PERIOD_CYC(PER), .BOOT_PULSE_CYC(PUL)) u_bfs_supervisor (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(addr), .i_avs_read(rd_en),
      .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pair_one_hold_n(hold1),
      .i_pair_two_hold_n(hold2), .i_gate_drive_supply_ok(gd_ok), .i_common_supply_ok(cm_ok),
      .i_overcurrent(oc), .i_overtemp_warn(warn), .i_thermal_shutdown(therm),
      .i_boot_cap_undervolt(buv), .i_duty_too_high(duty), .o_bridge_enable(en),
      .o_weak_pulldown(pd), .o_high_side_off(hso), .o_fault_n_o(f_o), .o_fault_n_oe(f_oe),
      .o_overtemp_warn_n_o(w_o), .o_overtemp_warn_n_oe(w_oe), .o_irq(irq));

   bfs_ctrl_model u_bfs_ctrl_model (
      .i_clk(i_clk), .i_run_one(run_one), .i_run_two(run_two), .i_fault_n_o(f_o),
      .i_fault_n_oe(f_oe), .i_warn_n_o(w_o), .i_warn_n_oe(w_oe), .o_pair_one_hold_n(hold1),
      .o_pair_two_hold_n(hold2), .o_fault_level(f_lvl), .o_warn_level(w_lvl));

   always #5 i_clk = ~i_clk;

   // ==========================================
   // checking and bus tasks
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      rd_en <= !wr;
      wr_en <= wr;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (wreq !== 1'b0 && n < 100);
      q = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      if (n >= 100) begin
         mismatches++;
         conclude();
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check("readdata", q & m, e);
   endtask

   task automatic outs(input logic [3:0] e_en, input logic [3:0] e_pd, input logic e_f,
                       input logic e_w);
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      check("bridge_enable", 32'(en), 32'(e_en));
      check("weak_pulldown", 32'(pd), 32'(e_pd));
      check("fault_pin", 32'(f_lvl), 32'(e_f));
      check("warn_pin", 32'(w_lvl), 32'(e_w));
      @(posedge i_clk);
   endtask

   // ==========================================
   // watchdog
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      $display("watchdog expired");
      conclude();
   end

   // ==========================================
   // scenarios
   initial begin
      i_clk = 1'b0;
      i_arst_n = 1'b0;
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      be = 4'hf;
      run_one = 1'b0;
      run_two = 1'b0;
      gd_ok = 1'b0;
      cm_ok = 1'b0;
      oc = 4'h0;
      warn = 1'b0;
      therm = 1'b0;
      buv = 4'h0;
      duty = 4'h0;
      repeat (16) @(posedge i_clk);
      i_arst_n <= 1'b1;
      outs(4'h0, 4'hf, 1'b1, 1'b1);
      gd_ok <= 1'b1;
      cm_ok <= 1'b1;
      outs(4'h0, 4'hf, 1'b1, 1'b1);
      run_one <= 1'b1;
      run_two <= 1'b1;
      outs(4'hf, 4'h0, 1'b1, 1'b1);
      run_one <= 1'b0;
      outs(4'hc, 4'h3, 1'b1, 1'b1);
      run_one <= 1'b1;
      bus(1'b1, ADDR_STATUS, 32'h1f);
      warn <= 1'b1;
      outs(4'hf, 4'h0, 1'b1, 1'b0);
      rd(ADDR_STATUS, 32'hffffffff, 32'h8);
      check("irq", 32'(irq), 32'h0);
      bus(1'b1, ADDR_MASK, 32'h8);
      outs(4'hf, 4'h0, 1'b1, 1'b0);
      check("irq", 32'(irq), 32'h1);
      warn <= 1'b0;
      bus(1'b1, ADDR_STATUS, 32'h8);
      outs(4'hf, 4'h0, 1'b1, 1'b1);
      check("irq", 32'(irq), 32'h0);
      bus(1'b1, 4'h2, 32'h1f);
      rd(4'h2, 32'hffffffff, 32'h0);
      be <= 4'he;
      bus(1'b1, ADDR_MASK, 32'h1f);
      be <= 4'hf;
      rd(ADDR_MASK, 32'hffffffff, 32'h8);
      oc <= 4'h2;
      repeat (2) @(negedge i_clk);
      check("bridge_enable", 32'(en), 32'hf);
      outs(4'h0, 4'h0, 1'b0, 1'b1);
      oc <= 4'h0;
      outs(4'h0, 4'h0, 1'b0, 1'b1);
      rd(ADDR_STATE, 32'h47, 32'h42);
      run_one <= 1'b0;
      outs(4'h0, 4'h3, 1'b1, 1'b1);
      run_one <= 1'b1;
      outs(4'hf, 4'h0, 1'b1, 1'b1);
      therm <= 1'b1;
      outs(4'h0, 4'h0, 1'b0, 1'b1);
      therm <= 1'b0;
      run_one <= 1'b0;
      outs(4'h0, 4'h3, 1'b1, 1'b1);
      run_one <= 1'b1;
      outs(4'h0, 4'h0, 1'b0, 1'b1);
      run_one <= 1'b0;
      run_two <= 1'b0;
      outs(4'h0, 4'hf, 1'b1, 1'b1);
      run_one <= 1'b1;
      run_two <= 1'b1;
      outs(4'hf, 4'h0, 1'b1, 1'b1);
      gd_ok <= 1'b0;
      warn <= 1'b1;
      outs(4'h0, 4'h0, 1'b0, 1'b0);
      gd_ok <= 1'b1;
      warn <= 1'b0;
      outs(4'hf, 4'h0, 1'b1, 1'b1);
      bus(1'b1, ADDR_CONTROL, 32'h1);
      rd(ADDR_CONTROL, 32'hffffffff, 32'h1);
      run_one <= 1'b0;
      run_two <= 1'b0;
      outs(4'h0, 4'h0, 1'b1, 1'b1);
      bus(1'b1, ADDR_CONTROL, 32'h0);
      run_one <= 1'b1;
      run_two <= 1'b1;
      buv <= 4'h1;
      duty <= 4'h4;
      outs(4'hf, 4'h0, 1'b1, 1'b1);
      c0 = 0;
      c2 = 0;
      cx = 0;
      repeat (2 * PER) begin
         @(negedge i_clk);
         c0 += int'(hso[0] === 1'b1);
         c2 += int'(hso[2] === 1'b1);
         cx += int'(hso[1] !== 1'b0 || hso[3] !== 1'b0);
      end
      check("recharge_boot", 32'(c0), 32'(2 * PUL));
      check("recharge_duty", 32'(c2), 32'(2 * PUL));
      check("recharge_idle", 32'(cx), 32'h0);
      rd(ADDR_STATUS, 32'h10, 32'h10);
      conclude();
   end
endmodule
`default_nettype wire
